// [rtl/eip_defs.svh]
// Contract
// - Drive select bit 0 gives full drive, 1 gives about one third drive.
// - Drive select has no effect on a pin configured as input.
// - Pull enable activates a pull device only while the pin is input.
// - After reset all pull enable bits of the eight-bit port are cleared.
// - Polarity 0: falling edge sets the flag; enabled pull is a pull-up.
// - Polarity 1: rising edge sets the flag; enabled pull is a pull-down.
// - Each interrupt enable bit masks (0) or allows (1) its own pin.
// - Each flag is set by the active edge selected by its polarity bit.
// - Writing 1 to a flag clears it; writing 0 leaves it unchanged.
// - Interrupt request is raised while any flag is set and enabled.
// - Second port data reads latch where direction is 1, else pin level.
// - Second port input register always returns present pin levels.
// - Writes to the second port input register are ignored.
// - Direction bit 0 makes the pin input, 1 makes it output.
// - Pin readback may lag a direction change by up to two cycles.
`ifndef EIP_DEFS_SVH
`define EIP_DEFS_SVH

// Register offsets
`define EIP_ADDR_W 6
`define EIP_OFS_DRIVE 6'h1b
`define EIP_OFS_PULL_EN 6'h1c
`define EIP_OFS_POLARITY 6'h1d
`define EIP_OFS_INT_EN 6'h1e
`define EIP_OFS_FLAGS 6'h1f
`define EIP_OFS_P_DIR 6'h1a
`define EIP_OFS_P_INPUT 6'h19
`define EIP_OFS_J_DATA 6'h28
`define EIP_OFS_J_LEVELS 6'h29
`define EIP_OFS_J_DIR 6'h2a

// Reset values
`define EIP_RST_BYTE 8'h00
`define EIP_RST_JBITS 2'h0

// Second port occupies bits 7:6
`define EIP_J_HI 7
`define EIP_J_LO 6
`define EIP_J_PAD 6'h00

// Edges count only once both sync stages and the last sample hold pins
`define EIP_ARM_DEPTH 3

`endif

// [rtl/eip_pkg.sv]
package eip_pkg;
	// Register bus request
	typedef struct packed {
		logic [5:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} eip_bus_s;

	// Per-pin pad controls, one bit per pin
	typedef struct packed {
		logic [7:0] out_val;
		logic [7:0] out_n_en;
		logic [7:0] reduced;
		logic [7:0] pull_up;
		logic [7:0] pull_down;
	} eip_pad_s;

	// Second port pad controls
	typedef struct packed {
		logic [1:0] out_val;
		logic [1:0] out_n_en;
	} eip_jpad_s;
endpackage : eip_pkg

// [rtl/eip_pin_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module eip_pin_sync #(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Raw pins and synchronised levels
	input wire logic [WIDTH-1:0] pin_raw,
	output logic [WIDTH-1:0] pin_sync
);
	logic [WIDTH-1:0] stage1;

	// Refused at elaboration, before any logic is built
	if (WIDTH < 1) begin : g_bad_width
		$error("eip_pin_sync: WIDTH must be at least 1");
	end

	// Two flops; stage1 feeds only pin_sync, never other logic
	always_ff @(posedge clk) begin
		if (!nrst) begin
			stage1 <= '0;
			pin_sync <= '0;
		end else begin
			stage1 <= pin_raw;
			pin_sync <= stage1;
		end
	end
endmodule : eip_pin_sync
`default_nettype wire

// [rtl/eip_port_regs.sv]
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "eip_defs.svh"
module eip_port_regs #(
	parameter int PINS = 8,
	parameter int JPINS = 2
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Register port
	input wire eip_pkg::eip_bus_s bus,
	output logic [7:0] rdata,
	// Eight-bit port pins
	input wire logic [PINS-1:0] p_pin_in,
	output eip_pkg::eip_pad_s p_pad,
	// Second port pins, bits 7:6 of its registers
	input wire logic [JPINS-1:0] j_pin_in,
	output eip_pkg::eip_jpad_s j_pad,
	// Interrupt request
	output logic irq
);
	import eip_pkg::*;

	// Register map fixes the widths; refuse anything else at elaboration
	if (PINS != 8) begin : g_bad_pins
		$error("eip_port_regs: PINS must be 8");
	end
	if (JPINS != 2) begin : g_bad_jpins
		$error("eip_port_regs: JPINS must be 2");
	end

	logic [7:0] drive_strength_select;
	logic [7:0] pull_device_enable;
	logic [7:0] pull_and_edge_polarity;
	logic [7:0] pin_interrupt_enable;
	logic [7:0] pin_edge_flags;
	logic [7:0] first_port_direction;
	logic [7:0] first_port_latch;
	logic [1:0] second_port_latch;
	logic [1:0] second_port_direction;
	logic [7:0] p_sync;
	logic [7:0] p_prev;
	logic [1:0] j_sync;
	logic [7:0] edge_seen;
	logic [7:0] next_flags;
	logic [7:0] next_rdata;
	logic wr_flags;
	logic wr_drive;
	logic wr_pull_en;
	logic wr_polarity;
	logic wr_int_en;
	logic wr_p_dir;
	logic wr_p_latch;
	logic wr_j_data;
	logic wr_j_dir;
	logic [`EIP_ARM_DEPTH-1:0] arm_fill;
	logic edges_armed;

	// Synchronise both ports in one instance
	eip_pin_sync #(
		.WIDTH(PINS + JPINS)
	) u_sync (
		.clk(clk),
		.nrst(nrst),
		.pin_raw({j_pin_in, p_pin_in}),
		.pin_sync({j_sync, p_sync})
	);

	// Write decode; second port level offset gets no enable, so its writes drop
	assign wr_drive = bus.wr && (bus.addr == `EIP_OFS_DRIVE);
	assign wr_pull_en = bus.wr && (bus.addr == `EIP_OFS_PULL_EN);
	assign wr_polarity = bus.wr && (bus.addr == `EIP_OFS_POLARITY);
	assign wr_int_en = bus.wr && (bus.addr == `EIP_OFS_INT_EN);
	assign wr_p_dir = bus.wr && (bus.addr == `EIP_OFS_P_DIR);
	assign wr_p_latch = bus.wr && (bus.addr == `EIP_OFS_P_INPUT);
	assign wr_j_data = bus.wr && (bus.addr == `EIP_OFS_J_DATA);
	assign wr_j_dir = bus.wr && (bus.addr == `EIP_OFS_J_DIR);

	// Drive select, only felt by pins that drive
	always_ff @(posedge clk) begin
		if (!nrst) begin
			drive_strength_select <= `EIP_RST_BYTE;
		end else if (wr_drive) begin
			drive_strength_select <= bus.wdata;
		end
	end

	// Pull enable; all pulls off out of reset
	always_ff @(posedge clk) begin
		if (!nrst) begin
			pull_device_enable <= `EIP_RST_BYTE;
		end else if (wr_pull_en) begin
			pull_device_enable <= bus.wdata;
		end
	end

	// Polarity picks both the active edge and the pull direction
	always_ff @(posedge clk) begin
		if (!nrst) begin
			pull_and_edge_polarity <= `EIP_RST_BYTE;
		end else if (wr_polarity) begin
			pull_and_edge_polarity <= bus.wdata;
		end
	end

	// Interrupt enable, one mask bit per pin
	always_ff @(posedge clk) begin
		if (!nrst) begin
			pin_interrupt_enable <= `EIP_RST_BYTE;
		end else if (wr_int_en) begin
			pin_interrupt_enable <= bus.wdata;
		end
	end

	// Eight-bit port direction; all inputs out of reset
	always_ff @(posedge clk) begin
		if (!nrst) begin
			first_port_direction <= `EIP_RST_BYTE;
		end else if (wr_p_dir) begin
			first_port_direction <= bus.wdata;
		end
	end

	// Eight-bit output latch
	always_ff @(posedge clk) begin
		if (!nrst) begin
			first_port_latch <= `EIP_RST_BYTE;
		end else if (wr_p_latch) begin
			first_port_latch <= bus.wdata;
		end
	end

	// Second port latch, upper two bits of the byte
	always_ff @(posedge clk) begin
		if (!nrst) begin
			second_port_latch <= `EIP_RST_JBITS;
		end else if (wr_j_data) begin
			second_port_latch <= bus.wdata[`EIP_J_HI:`EIP_J_LO];
		end
	end

	// Second port direction, upper two bits of the byte
	always_ff @(posedge clk) begin
		if (!nrst) begin
			second_port_direction <= `EIP_RST_JBITS;
		end else if (wr_j_dir) begin
			second_port_direction <= bus.wdata[`EIP_J_HI:`EIP_J_LO];
		end
	end

	// Previous synchronised sample for edge detection
	always_ff @(posedge clk) begin
		if (!nrst) begin
			p_prev <= `EIP_RST_BYTE;
		end else begin
			p_prev <= p_sync;
		end
	end

	// Stages reset to 0 under a high pin would fake an edge; wait them out
	always_ff @(posedge clk) begin
		if (!nrst) begin
			arm_fill <= '0;
		end else begin
			arm_fill <= {arm_fill[`EIP_ARM_DEPTH-2:0], 1'b1};
		end
	end
	// Limitation: edges in the first cycles after reset are not flagged
	assign edges_armed = arm_fill[`EIP_ARM_DEPTH-1];

	// Flags: an edge in the clearing cycle still sets the flag
	assign wr_flags = bus.wr && (bus.addr == `EIP_OFS_FLAGS);
	always_comb begin
		next_flags = pin_edge_flags;
		if (wr_flags) begin
			next_flags = next_flags & ~bus.wdata;
		end
		next_flags = next_flags | edge_seen;
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			pin_edge_flags <= `EIP_RST_BYTE;
		end else begin
			pin_edge_flags <= next_flags;
		end
	end

	// Masked request, independent per pin
	assign irq = |(pin_edge_flags & pin_interrupt_enable);

	// Pad controls per pin; output enable is active low
	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_pad
			logic is_out;
			assign is_out = first_port_direction[g];
			// Active edge by polarity, once the synchroniser has refilled
			assign edge_seen[g] = edges_armed & (pull_and_edge_polarity[g]
				? (p_sync[g] & ~p_prev[g])
				: (~p_sync[g] & p_prev[g]));
			assign p_pad.out_val[g] = first_port_latch[g];
			assign p_pad.out_n_en[g] = ~is_out;
			// Reduced drive only matters when driving
			assign p_pad.reduced[g] = is_out & drive_strength_select[g];
			// Pull only on inputs; polarity picks up or down
			assign p_pad.pull_up[g] = ~is_out & pull_device_enable[g]
				& ~pull_and_edge_polarity[g];
			assign p_pad.pull_down[g] = ~is_out & pull_device_enable[g]
				& pull_and_edge_polarity[g];
		end
	endgenerate

	assign j_pad.out_val = second_port_latch;
	assign j_pad.out_n_en = ~second_port_direction;

	// Read mux; synchronised levels lag pins by two cycles
	always_comb begin
		next_rdata = `EIP_RST_BYTE;
		case (bus.addr)
			`EIP_OFS_DRIVE: next_rdata = drive_strength_select;
			`EIP_OFS_PULL_EN: next_rdata = pull_device_enable;
			`EIP_OFS_POLARITY: next_rdata = pull_and_edge_polarity;
			`EIP_OFS_INT_EN: next_rdata = pin_interrupt_enable;
			`EIP_OFS_FLAGS: next_rdata = pin_edge_flags;
			`EIP_OFS_P_DIR: next_rdata = first_port_direction;
			`EIP_OFS_P_INPUT: next_rdata = p_sync;
			`EIP_OFS_J_DATA: next_rdata = {(second_port_direction
				& second_port_latch) | (~second_port_direction & j_sync),
				`EIP_J_PAD};
			`EIP_OFS_J_LEVELS:
				next_rdata = {j_sync, `EIP_J_PAD};
			`EIP_OFS_J_DIR: next_rdata = {second_port_direction, `EIP_J_PAD};
			default: next_rdata = `EIP_RST_BYTE;
		endcase
	end

	// Read data registered, valid the cycle after the strobe only
	always_ff @(posedge clk) begin
		if (!nrst) begin
			rdata <= `EIP_RST_BYTE;
		end else if (bus.rd) begin
			rdata <= next_rdata;
		end else begin
			rdata <= `EIP_RST_BYTE;
		end
	end
endmodule : eip_port_regs
`default_nettype wire

// [bench/eip_pins_model.sv]
`timescale 1ns/1ps
`default_nettype none
module eip_pins_model (
	// Clock
	input wire logic clk,
	// Pad controls
	input wire eip_pkg::eip_pad_s p_pad,
	input wire eip_pkg::eip_jpad_s j_pad,
	// Board drive
	input wire logic [7:0] bd,
	input wire logic [7:0] bd_en,
	input wire logic [1:0] jbd,
	// Pin levels
	output logic [7:0] p_pin_in,
	output logic [1:0] j_pin_in
);
	import eip_pkg::*;
	logic tg = 1'b0;
	// Floating pin toggles, so no stale level passes
	always @(posedge clk) tg <= ~tg;
	// Port drive wins, then board, then pull
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (!p_pad.out_n_en[i]) p_pin_in[i] = p_pad.out_val[i];
			else if (bd_en[i]) p_pin_in[i] = bd[i];
			else if (p_pad.pull_up[i]) p_pin_in[i] = 1'b1;
			else if (p_pad.pull_down[i]) p_pin_in[i] = 1'b0;
			else p_pin_in[i] = tg;
		end
	end
	// Second port pins
	assign j_pin_in = ~j_pad.out_n_en & j_pad.out_val | j_pad.out_n_en & jbd;
endmodule : eip_pins_model
`default_nettype wire

// [bench/eip_port_regs_props.sv]
`timescale 1ns/1ps
`default_nettype none
module eip_port_regs_props #(
	parameter int PINS = 8,
	parameter int JPINS = 2
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Watched ports
	input wire eip_pkg::eip_bus_s bus,
	input wire logic [7:0] rdata,
	input wire logic [PINS-1:0] p_pin_in,
	input wire eip_pkg::eip_pad_s p_pad,
	input wire logic [JPINS-1:0] j_pin_in,
	input wire eip_pkg::eip_jpad_s j_pad,
	input wire logic irq
);
	import eip_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// Strobe at one offset
	sequence wr_to(a); bus.wr && bus.addr == a; endsequence
	sequence rd_at(a); bus.rd && bus.addr == a; endsequence
	rst_pull_a: assert property ($rose(nrst) |->
		(p_pad.pull_up | p_pad.pull_down) == 8'h00) else $error("pull on");
	drv_in_a: assert property (
		(p_pad.reduced & p_pad.out_n_en) == 8'h00) else $error("drive on input");
	pull_out_a: assert property (((p_pad.pull_up |
		p_pad.pull_down) & ~p_pad.out_n_en) == 8'h00) else $error("pull on out");
	pull_both_a: assert property (
		(p_pad.pull_up & p_pad.pull_down) == 8'h00) else $error("both pulls");
	dir_write_a: assert property (wr_to(6'h1a) |=>
		p_pad.out_n_en == ~$past(bus.wdata)) else $error("direction");
	drv_write_a: assert property (wr_to(6'h1b) |=> p_pad.reduced ==
		($past(bus.wdata) & ~p_pad.out_n_en)) else $error("drive select");
	irq_mask_a: assert property (wr_to(6'h1e) ##0
		bus.wdata == 8'h00 |=> !irq) else $error("irq not masked");
	lvl_pad_a: assert property (rd_at(6'h29) |=>
		rdata[5:0] == 6'h00) else $error("level pad bits");
	jdata_rd_a: assert property (rd_at(6'h28) ##0 j_pad.out_n_en == 2'h0
		|=> rdata[7:6] == $past(j_pad.out_val)) else $error("latch read");
endmodule : eip_port_regs_props
bind eip_port_regs eip_port_regs_props #(.PINS(PINS), .JPINS(JPINS)) chk (
	.clk, .nrst, .bus, .rdata, .p_pin_in, .p_pad, .j_pin_in, .j_pad, .irq);
`default_nettype wire

// [bench/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
	import eip_pkg::*;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	eip_bus_s bus = '0;
	logic [7:0] rdata, p_pin_in, bd = 8'h00, bd_en = 8'hff;
	logic [1:0] j_pin_in, jbd = 2'h0;
	eip_pad_s p_pad;
	eip_jpad_s j_pad;
	logic irq;
	int errors = 0, n_compared = 0, cyc = 0;
	logic [5:0] ra [8] = '{6'h1a, 6'h1b, 6'h1c, 6'h1d, 6'h1e, 6'h1f, 6'h2a, 6'h30};
	// 200 MHz
	always #2.5 clk = ~clk;
	eip_port_regs DUT (.clk, .nrst, .bus, .rdata, .p_pin_in, .p_pad,
		.j_pin_in, .j_pad, .irq);
	eip_pins_model board (.clk, .p_pad, .j_pad, .bd, .bd_en, .jbd,
		.p_pin_in, .j_pin_in);
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge clk);
		bus <= '{a, d, 1'b1, 1'b0};
		@(posedge clk);
		bus <= '0;
	endtask : wr
	// Data stand only in the cycle after the strobe
	task automatic rd(input logic [5:0] a, input logic [7:0] e);
		@(posedge clk);
		bus <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk);
		bus <= '0;
		#1 chk(rdata, e);
	endtask : rd
	task automatic end_sim;
		$display("errors=%0d compared=%0d", errors, n_compared);
		if (errors == 0 && n_compared > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : end_sim
	// Hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			errors++;
			end_sim();
		end
	end
	// Registers, pads, edges, second port
	initial begin
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		for (int i = 0; i < 8; i++) rd(ra[i], 8'h00);
		for (int i = 0; i < 5; i++) begin
			wr(ra[i], 8'ha5);
			rd(ra[i], 8'ha5);
		end
		wr(6'h1a, 8'h0f);
		wr(6'h1b, 8'hff);
		wr(6'h1c, 8'hff);
		wr(6'h1d, 8'h33);
		#1 chk(p_pad.reduced, 8'h0f);
		chk(p_pad.pull_up, 8'hc0);
		chk(p_pad.pull_down, 8'h30);
		wr(6'h1a, 8'h00);
		wr(6'h1d, 8'h0f);
		wr(6'h1e, 8'h01);
		// Board lets go, pins settle on pulls
		@(posedge clk) bd_en <= 8'h00;
		repeat (4) @(posedge clk);
		rd(6'h19, 8'hf0);
		@(posedge clk) bd_en <= 8'hff;
		repeat (4) @(posedge clk);
		wr(6'h1f, 8'hff);
		rd(6'h1f, 8'h00);
		@(posedge clk) bd <= 8'hff;
		repeat (4) @(posedge clk);
		rd(6'h1f, 8'h0f);
		chk({7'h00, irq}, 8'h01);
		@(posedge clk) bd <= 8'h00;
		repeat (4) @(posedge clk);
		rd(6'h1f, 8'hff);
		wr(6'h1f, 8'h01);
		rd(6'h1f, 8'hfe);
		chk({7'h00, irq}, 8'h00);
		wr(6'h1f, 8'h00);
		rd(6'h1f, 8'hfe);
		wr(6'h1e, 8'h80);
		#1 chk({7'h00, irq}, 8'h01);
		wr(6'h1e, 8'h00);
		wr(6'h1f, 8'hff);
		rd(6'h1f, 8'h00);
		wr(6'h2a, 8'hc0);
		wr(6'h28, 8'h40);
		repeat (3) @(posedge clk);
		rd(6'h28, 8'h40);
		rd(6'h29, 8'h40);
		wr(6'h2a, 8'h00);
		@(posedge clk) jbd <= 2'h2;
		repeat (3) @(posedge clk);
		rd(6'h28, 8'h80);
		wr(6'h29, 8'hff);
		rd(6'h2a, 8'h00);
		rd(6'h29, 8'h80);
		// Eight-bit latch onto pins turned to outputs
		wr(6'h19, 8'h5a);
		wr(6'h1a, 8'hff);
		#1 chk(p_pad.out_val, 8'h5a);
		chk(p_pad.out_n_en, 8'h00);
		repeat (3) @(posedge clk);
		rd(6'h19, 8'h5a);
		// Second reset under high pins; rising polarity set at once
		@(posedge clk) bd <= 8'hff;
		nrst <= 1'b0;
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		wr(6'h1d, 8'hff);
		repeat (4) @(posedge clk);
		rd(6'h1f, 8'h00);
		rd(6'h1c, 8'h00);
		rd(6'h1a, 8'h00);
		end_sim();
	end
endmodule : tb
`default_nettype wire
